/* File: spi_err_pkg.sv */
// Shared constants and carrier types for the serial port error logic.
// Assumes a single system clock domain; pins are synchronised in the core.
package spi_err_pkg;
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned char_bits = 8;
  localparam int unsigned rate_width = 16;
  localparam logic [15:0] rate_reload_reset = 16'h0000;
  localparam logic [7:0] rx_data_reset = 8'h00;
  localparam logic [2:0] bit_count_reset = 3'h0;
  localparam logic [2:0] bit_count_last = 3'h7;
  localparam logic [15:0] rate_count_zero = 16'h0000;
  localparam logic [15:0] rate_count_step = 16'h0001;

  // ----------------------------------------------------------------
  // Flag vector layout
  // ----------------------------------------------------------------
  localparam int unsigned flag_count = 6;
  localparam int unsigned pos_transmit_empty = 0;
  localparam int unsigned pos_transmit_underrun = 1;
  localparam int unsigned pos_collision = 2;
  localparam int unsigned pos_abort = 3;
  localparam int unsigned pos_receive_overrun = 4;
  localparam int unsigned pos_receive_data_full = 5;

  // Static configuration carried as one group
  typedef struct packed {
    logic port_enable;
    logic master_select;
    logic select_pin_direction;
    logic rate_counter_control;
    logic [15:0] rate_reload;
  } cfg_t;

  // Software write-one clear strobes
  typedef struct packed {
    logic collision;
    logic receive_overrun;
    logic abort;
  } clear_t;

  typedef enum logic [1:0] {
    slave_idle,
    slave_shift,
    slave_done
  } slave_state_t;
endpackage

/* File: spi_err_flag.sv */
// Sticky status flag with write-one clear; a set in the clear cycle wins.
// Assumes set and clear come from the system clock domain.
`timescale 1ns/100ps
module spi_err_flag (
  input wire logic mclk,       // System clock
  input wire logic resetn,     // Async reset, active low
  input wire logic clk_en,     // Clock enable
  input wire logic set,        // Hardware set request
  input wire logic clear,      // Software write-one clear
  output logic flag            // Sticky flag
);
  // Sticky update, set over clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flag <= 1'b0;
    end else if (clk_en) begin
      if (set) begin
        flag <= 1'b1;
      end else if (clear) begin
        flag <= 1'b0;
      end
    end
  end
endmodule

/* File: spi_error_detection.sv */
// Error detection for the serial port: mode fault, overrun, slave abort.
// Assumes serial clock and select pins are asynchronous and are resynchronised
// here; the shift data path itself lives outside, reporting byte completion.
`timescale 1ns/100ps
module spi_error_detection (
  input wire logic mclk,                   // System clock, 250 MHz
  input wire logic resetn,                 // Async reset, active low
  input wire logic clk_en,                 // Freezes all state when low
  input wire spi_err_pkg::cfg_t cfg,       // Mode and reload configuration
  input wire spi_err_pkg::clear_t clear,   // Write-one clear strobes
  input wire logic select_n_pin,           // Slave select pin, async
  input wire logic sclk_pin,               // Serial clock pin, async
  input wire logic byte_done,              // Shifter finished a character
  input wire logic [7:0] shift_data,       // Byte from the shifter
  input wire logic read_rx,                // Software consumed receive data
  input wire logic write_tx,               // Software loaded transmit data
  output logic [7:0] rx_data,              // Receive data register
  output logic [5:0] status,               // Status flag vector
  output logic sclk_stall,                 // Master clock pause request
  output logic irq                         // Interrupt pulse
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sel_meta;
  logic sel_sync;
  logic sck_meta;
  logic sck_sync;
  logic sck_prev;
  logic sel_prev;

  // Two flops per pin, plus history for edge detection
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_meta <= 1'b1;
      sel_sync <= 1'b1;
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_prev <= 1'b0;
      sel_prev <= 1'b1;
    end else if (clk_en) begin
      sel_meta <= select_n_pin;
      sel_sync <= sel_meta;
      sck_meta <= sclk_pin;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
      sel_prev <= sel_sync;
    end
  end

  logic selected;
  logic sck_edge;
  logic sel_rise;
  logic slave_on;
  logic master_on;
  assign selected = !sel_sync;
  assign sck_edge = sck_sync ^ sck_prev;
  assign sel_rise = sel_sync && !sel_prev;
  assign slave_on = cfg.port_enable && !cfg.master_select;
  assign master_on = cfg.port_enable && cfg.master_select;

  // ----------------------------------------------------------------
  // Slave control and bit counting
  // ----------------------------------------------------------------
  spi_err_pkg::slave_state_t state;
  logic [2:0] bit_count;
  logic early_release;
  logic watchdog_expire;
  logic slave_abort;
  assign early_release = slave_on && sel_rise && (state == spi_err_pkg::slave_shift);
  assign slave_abort = early_release || watchdog_expire;

  // Slave sequencing, abort forces idle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= spi_err_pkg::slave_idle;
      bit_count <= spi_err_pkg::bit_count_reset;
    end else if (clk_en) begin
      if (slave_abort || !slave_on) begin
        state <= spi_err_pkg::slave_idle;
        bit_count <= spi_err_pkg::bit_count_reset;
      end else begin
        unique case (state)
          spi_err_pkg::slave_idle: begin
            if (selected) begin
              state <= spi_err_pkg::slave_shift;
            end
          end
          spi_err_pkg::slave_shift: begin
            if (byte_done) begin
              state <= spi_err_pkg::slave_done;
              bit_count <= spi_err_pkg::bit_count_reset;
            end else if (sck_edge && sck_sync) begin
              bit_count <= bit_count + 3'h1;
            end
          end
          spi_err_pkg::slave_done: begin
            if (!selected) begin
              state <= spi_err_pkg::slave_idle;
            end else if (sck_edge) begin
              state <= spi_err_pkg::slave_shift;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Rate generator as slave clock watchdog
  // ----------------------------------------------------------------
  logic [15:0] rate_count;
  logic watchdog_on;
  assign watchdog_on = slave_on && cfg.rate_counter_control;
  assign watchdog_expire = watchdog_on && selected && (rate_count == spi_err_pkg::rate_count_zero);

  // Reload while deselected, on clock edge or at zero, count down otherwise
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rate_count <= spi_err_pkg::rate_reload_reset;
    end else if (clk_en) begin
      if (!watchdog_on || !selected || sck_edge) begin
        rate_count <= cfg.rate_reload;
      end else if (rate_count != spi_err_pkg::rate_count_zero) begin
        rate_count <= rate_count - spi_err_pkg::rate_count_step;
      end else begin
        rate_count <= cfg.rate_reload;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive path, overrun and master stall
  // ----------------------------------------------------------------
  logic rx_full;
  logic tx_empty;
  logic overrun_set;
  logic rx_accept;
  assign overrun_set = byte_done && rx_full && !master_on;
  assign rx_accept = byte_done && !rx_full;

  // Receive register keeps the first byte while full
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_data <= spi_err_pkg::rx_data_reset;
    end else if (clk_en && rx_accept) begin
      rx_data <= shift_data;
    end
  end

  // Receive full and transmit empty requests
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_full <= 1'b0;
      tx_empty <= 1'b1;
    end else if (clk_en) begin
      if (rx_accept) begin
        rx_full <= 1'b1;
      end else if (read_rx) begin
        rx_full <= 1'b0;
      end
      if (byte_done) begin
        tx_empty <= 1'b1;
      end else if (write_tx || !cfg.port_enable) begin
        tx_empty <= 1'b0;
      end
    end
  end

  // Master pauses its clock while requests are pending
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclk_stall <= 1'b0;
    end else if (clk_en) begin
      sclk_stall <= master_on && (rx_full || tx_empty);
    end
  end

  // ----------------------------------------------------------------
  // Sticky error flags
  // ----------------------------------------------------------------
  logic mode_fault;
  logic col_flag;
  logic ovr_flag;
  logic abt_flag;
  logic underrun_flag;
  assign mode_fault = master_on && !cfg.select_pin_direction && selected;

  spi_err_flag u_col (
    .mclk(mclk),
    .resetn(resetn),
    .clk_en(clk_en),
    .set(mode_fault),
    .clear(clear.collision),
    .flag(col_flag)
  );

  spi_err_flag u_ovr (
    .mclk(mclk),
    .resetn(resetn),
    .clk_en(clk_en),
    .set(overrun_set),
    .clear(clear.receive_overrun),
    .flag(ovr_flag)
  );

  spi_err_flag u_abt (
    .mclk(mclk),
    .resetn(resetn),
    .clk_en(clk_en),
    .set(slave_abort),
    .clear(clear.abort),
    .flag(abt_flag)
  );

  // Underrun: slave completes a byte with no fresh transmit data
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      underrun_flag <= 1'b0;
    end else if (clk_en) begin
      if (byte_done && slave_on && tx_empty) begin
        underrun_flag <= 1'b1;
      end else if (write_tx) begin
        underrun_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status output and interrupt pulse
  // ----------------------------------------------------------------
  logic [5:0] next_status;
  always_comb begin
    next_status = '0;
    next_status[spi_err_pkg::pos_transmit_empty] = tx_empty;
    next_status[spi_err_pkg::pos_transmit_underrun] = underrun_flag;
    next_status[spi_err_pkg::pos_collision] = col_flag;
    next_status[spi_err_pkg::pos_abort] = abt_flag;
    next_status[spi_err_pkg::pos_receive_overrun] = ovr_flag;
    next_status[spi_err_pkg::pos_receive_data_full] = rx_full;
  end

  // Registered status, pulse on any newly set bit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      status <= next_status;
      irq <= |(next_status & ~status);
    end
  end
endmodule

/* File: spi_error_checker_assertions.sv */
// Concurrent checks on the error logic, watching the core's top ports.
// Assumes one clock domain and the port names of the core; checks pause while clk_en is low.
`timescale 1ns/100ps
module spi_error_checker (
  input wire logic mclk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic clk_en, // Clock enable, state frozen while low
  input wire spi_err_pkg::cfg_t cfg, // Mode and reload configuration
  input wire spi_err_pkg::clear_t clear, // Write-one clear strobes
  input wire logic select_n_pin, // Select pin
  input wire logic byte_done, // Character complete
  input wire logic read_rx, // Receive data consumed
  input wire logic [5:0] status, // Status flags
  input wire logic irq // Interrupt pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn || !clk_en);
  // Flag relations, each tied to its cause
  a_overrun_on_full: assert property (byte_done && status[5] && !read_rx && !$past(read_rx)
    && !cfg.master_select |-> ##2 status[4]) else $error("overrun not flagged");
  a_master_no_overrun: assert property (cfg.master_select && $past(cfg.master_select, 4)
    |-> !$rose(status[4])) else $error("overrun in master mode");
  a_mode_fault_seen: assert property (cfg.port_enable && cfg.master_select
    && !cfg.select_pin_direction && !select_n_pin |-> ##[1:6] status[2])
    else $error("mode fault missed");
  a_collision_clear: assert property (clear.collision && !cfg.master_select
    && !$past(cfg.master_select, 6) |-> ##2 !status[2]) else $error("collision not cleared");
  a_collision_holds: assert property (status[2] && !clear.collision
    && !$past(clear.collision) |=> status[2]) else $error("collision lost");
  a_overrun_clear: assert property (clear.receive_overrun && !byte_done
    |-> ##2 !status[4]) else $error("overrun not cleared");
  a_abort_clear: assert property (clear.abort && select_n_pin && $past(select_n_pin, 8)
    && !cfg.rate_counter_control |-> ##2 !status[3]) else $error("abort not cleared");
  a_irq_on_rise: assert property (|(status[5:1] & ~$past(status[5:1])) |-> irq)
    else $error("no pulse on flag rise");
  a_irq_needs_rise: assert property (irq |-> (status & ~$past(status)) != 6'h00)
    else $error("pulse without flag rise");
endmodule
bind spi_error_detection spi_error_checker chk (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
  .cfg(cfg),
  .clear(clear), .select_n_pin(select_n_pin), .byte_done(byte_done), .read_rx(read_rx),
  .status(status), .irq(irq));

/* File: spi_remote_master.sv */
// Behavioural remote master driving the select and serial clock pins.
// Assumes the bench calls its tasks; clock stands still between frames.
`timescale 1ns/100ps
module spi_remote_master (
  output logic select_n, // Select to the device, active low
  output logic sclk // Serial clock, 64 ns period
);
  // Idle levels
  initial begin
    select_n = 1'b1;
    sclk = 1'b0;
  end
  // Drive the select level
  task automatic sel(input logic v);
    select_n <= v;
  endtask
  // Clock edges 32 ns apart, well inside the watchdog reload
  task automatic edges(input int n);
    repeat (n) begin
      #32 sclk <= ~sclk;
    end
    // Step off the system clock edge so the caller resumes at a known point
    #1;
  endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the serial port error logic.
// Assumes the remote master model and the checker bound to the core.
`timescale 1ns/100ps
module tb;
  typedef struct {int due; logic [6:0] m; logic [6:0] v; logic rxon; logic [7:0] rx;} note_t;
  logic mclk, resetn, byte_done, read_rx, write_tx, select_n, sclk, sclk_stall, irq;
  logic clk_en;
  logic [7:0] shift_data, rx_data, a, b;
  logic [5:0] status;
  spi_err_pkg::cfg_t cfg;
  spi_err_pkg::clear_t clear;
  note_t q[$];
  int cyc = 0, err_total = 0, checked = 0;
  spi_remote_master rm (.select_n(select_n), .sclk(sclk));
  spi_error_detection dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .cfg(cfg),
    .clear(clear), .select_n_pin(select_n), .sclk_pin(sclk), .byte_done(byte_done),
    .shift_data(shift_data), .read_rx(read_rx), .write_tx(write_tx), .rx_data(rx_data),
    .status(status), .sclk_stall(sclk_stall), .irq(irq));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic expect_at(input int d, input logic [6:0] m, input logic [6:0] v,
    input logic rxon);
    q.push_back('{cyc + d, m, v, rxon, a});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic strobe(input logic [7:0] d, input logic clr);
    byte_done <= 1'b1;
    shift_data <= d;
    clear.receive_overrun <= clr;
    tick(1);
  endtask
  task automatic drop();
    byte_done <= 1'b0;
    clear.receive_overrun <= 1'b0;
    tick(1);
  endtask
  // Monitor: compares due notes, and cuts a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      err_total++;
      give_verdict();
    end
    while (q.size() > 0 && q[0].due == cyc) begin
      checked++;
      if ((({sclk_stall, status} ^ q[0].v) & q[0].m) !== 7'h00 ||
          (q[0].rxon && rx_data !== q[0].rx)) begin
        err_total++;
        $display("[ERR] %0t status %h stall %b rx %h", $time, status, sclk_stall, rx_data);
      end
      void'(q.pop_front());
    end
  end
  // Stimulus
  initial begin
    {resetn, byte_done, read_rx, write_tx, shift_data, clear} = '0;
    cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 16'h0020};
    clk_en = 1'b1;
    void'($urandom(66029));
    // Watchdog reload kept above the 8-cycle link clock gap
    cfg.rate_reload = 16'h0014 + 16'($urandom_range(31));
    tick(4);
    resetn <= 1'b1;
    tick(4);
    a = 8'($urandom);
    b = 8'($urandom);
    expect_at(3, 7'h20, 7'h20, 1);
    strobe(a, 1'b0);
    expect_at(3, 7'h10, 7'h10, 1);
    strobe(b, 1'b0);
    expect_at(3, 7'h10, 7'h10, 1);
    strobe(~b, 1'b1);
    drop();
    tick(2);
    clear.receive_overrun <= 1'b1;
    expect_at(3, 7'h10, 7'h00, 1);
    tick(1);
    clear.receive_overrun <= 1'b0;
    read_rx <= 1'b1;
    tick(1);
    read_rx <= 1'b0;
    a = b;
    expect_at(3, 7'h30, 7'h20, 1);
    strobe(b, 1'b0);
    drop();
    cfg.master_select <= 1'b1;
    cfg.select_pin_direction <= 1'b1;
    tick(6);
    strobe(b, 1'b0);
    expect_at(3, 7'h50, 7'h40, 0);
    strobe(b, 1'b0);
    drop();
    read_rx <= 1'b1;
    write_tx <= 1'b1;
    tick(1);
    {read_rx, write_tx} <= 2'b00;
    cfg.select_pin_direction <= 1'b0;
    rm.sel(1'b0);
    tick(10);
    expect_at(1, 7'h44, 7'h04, 0);
    cfg.master_select <= 1'b0;
    rm.sel(1'b1);
    tick(8);
    expect_at(4, 7'h04, 7'h04, 0);
    tick(4);
    clear.collision <= 1'b1;
    clear.abort <= 1'b1;
    expect_at(3, 7'h0c, 7'h00, 0);
    tick(1);
    clear.collision <= 1'b0;
    clear.abort <= 1'b0;
    // Two aborted frames: the second needs the slave logic back at idle
    for (int i = 0; i < 2; i++) begin
      rm.sel(1'b0);
      rm.edges(6);
      rm.sel(1'b1);
      tick(12);
      expect_at(1, 7'h08, 7'h08, 0);
      tick(2);
      clear.abort <= 1'b1;
      expect_at(3, 7'h08, 7'h00, 0);
      tick(1);
      clear.abort <= 1'b0;
      tick(4);
    end
    cfg.rate_counter_control <= 1'b1;
    tick(2);
    rm.sel(1'b0);
    rm.edges(40);
    tick(20);
    expect_at(1, 7'h08, 7'h00, 0);
    tick(60);
    expect_at(1, 7'h08, 7'h08, 0);
    tick(2);
    rm.sel(1'b1);
    cfg.rate_counter_control <= 1'b0;
    tick(12);
    clear.abort <= 1'b1;
    tick(1);
    clear.abort <= 1'b0;
    tick(6);
    // Frozen clock enable: a strobe must leave receive full, transmit empty and the data alone
    clk_en <= 1'b0;
    expect_at(3, 7'h21, 7'h00, 1);
    strobe(~b, 1'b0);
    drop();
    clk_en <= 1'b1;
    a = ~b;
    expect_at(3, 7'h21, 7'h21, 1);
    strobe(a, 1'b0);
    drop();
    // Disabling the port withdraws the transmit-empty request
    cfg.port_enable <= 1'b0;
    expect_at(3, 7'h01, 7'h00, 0);
    tick(3);
    cfg.port_enable <= 1'b1;
    tick(2);
    give_verdict();
  end
endmodule
